// *** rtl/amg_pkg.sv ***
package amg_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] CTRL_OFFSET     = 4'h0;
    localparam logic [3:0] STATUS_OFFSET   = 4'h4;
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic [3:0] GAIN_LSB        = 4'h0;
    localparam logic [3:0] PD_LSB          = 4'h4;
    localparam logic [3:0] CAL_BIT         = 4'h7;
    localparam int         ST_GAIN_LSB     = 0;
    localparam int         ST_CMP_AB_BIT   = 4;
    localparam int         ST_CMP_CD_BIT   = 5;
    localparam int         ST_CONV_BIT     = 6;
    localparam int         ST_PIN_MODE_BIT = 7;
    localparam int         ST_INT_REF_BIT  = 8;
    localparam int         ST_READY_BIT    = 9;
    localparam int         ST_CAL_BIT      = 10;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

    // ****************************************
    // codes
    // ****************************************
    localparam logic [3:0] GAIN_SW_CTRL    = 4'h0;
    localparam logic [3:0] GAIN_DEFAULT    = 4'h1;
    localparam logic [3:0] GAIN_RESERVED   = 4'hf;
    localparam logic [2:0] PD_ALL_OFF      = 3'h0;
    localparam logic [2:0] PD_CONV_ONLY    = 3'h1;
    localparam logic [2:0] PD_CD_ONLY      = 3'h2;
    localparam logic [2:0] PD_AB_ONLY      = 3'h3;
    localparam logic [2:0] PD_CMP_ONLY     = 3'h4;
    localparam logic [2:0] PD_ALL_ON       = 3'h5;
    localparam logic [2:0] PD_RESET        = 3'h7;

    // ****************************************
    // wake-up timing
    // ****************************************
    localparam int         CLK_MHZ         = 125;
    localparam int         EXT_REF_WAKE_US = 15;
    localparam int         INT_REF_WAKE_US = 240;
    localparam int         EXT_REF_WAKE_CYC = EXT_REF_WAKE_US * CLK_MHZ;
    localparam int         INT_REF_WAKE_CYC = INT_REF_WAKE_US * CLK_MHZ;
    localparam int         WAKE_CNT_W      = 15;

    typedef struct packed {
        logic       cal;
        logic [2:0] pd;
        logic [3:0] gain;
    } amg_cfg_s;

    typedef struct packed {
        logic cmp_ab;
        logic cmp_cd;
        logic conv;
    } amg_pwr_s;

    typedef enum logic [1:0] {
        WAKE_WAIT  = 2'b00,
        WAKE_READY = 2'b01
    } amg_wake_e;

endpackage

// *** rtl/amg_sync.sv ***
`timescale 1ns/10ps
module amg_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] stage1;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= '0;
            q      <= '0;
        end
        else
        begin
            stage1 <= d;
            q      <= stage1;
        end
    end

endmodule

// *** rtl/amg_wake_timer.sv ***
`timescale 1ns/10ps
module amg_wake_timer (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         start,
    input  wire logic [amg_pkg::WAKE_CNT_W-1:0] load,
    output logic                              busy
);

    logic [amg_pkg::WAKE_CNT_W-1:0] count;
    logic [amg_pkg::WAKE_CNT_W-1:0] next_count;

    assign next_count = start ? load : ((count != '0) ? count - 1'b1 : count);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= '0;
            busy  <= 1'b0;
        end
        else
        begin
            count <= next_count;
            busy  <= (next_count != '0);
        end
    end

endmodule

// *** rtl/amg_ctrl.sv ***
`timescale 1ns/10ps
// How it works
// - any gain pin high selects pin-driven mode
// - all gain pins low selects control register mode
// - gain codes 1..14 map to 1,2,3,4,6,8,12,16,24,32,48,64,96,128
// - control register mode takes gain from the register gain field
// - pin mode: gain, power, reference and calibration follow the pins
// - power mode from register or pins, pairs powered independently
// - power code decode per table, 111 all off
// - all power pins low in pin mode powers everything down
// - code 111 resets only in pin mode, else just powers down
// - reset clears registers, leaves comparators and converters off
// - mode follows gain pins every cycle from power-up on, registers start at zero
// - control register mode powers up all off with gain 1
// - external reference needs 15 us before ready
// - internal reference needs 240 us before ready
// - register bits 6:4 power code, bits 3:0 gain code
// - reference pin high picks internal reference, low external
module amg_ctrl #(
    parameter int INT_WAKE_CYC = amg_pkg::INT_REF_WAKE_CYC
) (
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    input  wire logic        GAIN_SEL_BIT3,
    input  wire logic        GAIN_SEL_BIT2,
    input  wire logic        GAIN_SEL_BIT1,
    input  wire logic        GAIN_SEL_BIT0,
    input  wire logic        PWR_SEL_BIT2,
    input  wire logic        PWR_SEL_BIT1,
    input  wire logic        PWR_SEL_BIT0,
    input  wire logic        REFERENCE_SELECT,
    input  wire logic        CAL_PIN,
    output logic             PIN_MODE,
    output logic [3:0]       AMP_GAIN_CODE,
    output logic [7:0]       AMP_GAIN_FACTOR,
    output logic             CMP_AB_ON,
    output logic             CMP_CD_ON,
    output logic             CONV_ON,
    output logic             INT_REF_EN,
    output logic             CAL_START,
    output logic             READY,
    input  wire logic [31:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [31:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);

    // ****************************************
    // functions
    // ****************************************
    function automatic amg_pkg::amg_pwr_s pd_decode(input logic [2:0] code);
        case (code)
            amg_pkg::PD_CONV_ONLY: return '{cmp_ab: 1'b0, cmp_cd: 1'b0, conv: 1'b1};
            amg_pkg::PD_CD_ONLY:   return '{cmp_ab: 1'b0, cmp_cd: 1'b1, conv: 1'b0};
            amg_pkg::PD_AB_ONLY:   return '{cmp_ab: 1'b1, cmp_cd: 1'b0, conv: 1'b0};
            amg_pkg::PD_CMP_ONLY:  return '{cmp_ab: 1'b1, cmp_cd: 1'b1, conv: 1'b0};
            amg_pkg::PD_ALL_ON:    return '{cmp_ab: 1'b1, cmp_cd: 1'b1, conv: 1'b1};
            default:               return '0;
        endcase
    endfunction

    function automatic logic [7:0] gain_factor(input logic [3:0] code);
        logic [15:0][7:0] tab;
        tab = {8'h01, 8'h80, 8'h60, 8'h40, 8'h30, 8'h20, 8'h18, 8'h10,
               8'h0c, 8'h08, 8'h06, 8'h04, 8'h03, 8'h02, 8'h01, 8'h01};
        return tab[code];
    endfunction

    function automatic logic addr_hit(input logic [31:0] a, input logic [3:0] off);
        return (a[31:4] == 28'h0000000) && (a[3:0] == off);
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [3:0]  gain_s;
    logic [2:0]  pd_s;
    logic        ref_s;
    logic        cal_s;

    amg_sync #(.W(9)) u_sync (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .d     ({GAIN_SEL_BIT3, GAIN_SEL_BIT2, GAIN_SEL_BIT1, GAIN_SEL_BIT0,
                 PWR_SEL_BIT2, PWR_SEL_BIT1, PWR_SEL_BIT0, REFERENCE_SELECT, CAL_PIN}),
        .q     ({gain_s, pd_s, ref_s, cal_s})
    );

    // ****************************************
    // mode and configuration decode
    // ****************************************
    amg_pkg::amg_cfg_s cfg;
    amg_pkg::amg_pwr_s next_pwr;
    logic              pin_mode_w;
    logic              pin_reset;
    logic [3:0]        src_gain;
    logic [2:0]        src_pd;
    logic [3:0]        next_gain;
    logic              next_cal;

    assign pin_mode_w = |gain_s;
    assign pin_reset  = pin_mode_w && (pd_s == amg_pkg::PD_RESET);
    assign src_pd     = pin_mode_w ? pd_s : cfg.pd;
    assign src_gain   = pin_mode_w ? gain_s : cfg.gain;
    // reserved code holds gain; zero field means gain 1
    assign next_gain  = (src_gain == amg_pkg::GAIN_RESERVED) ? AMP_GAIN_CODE :
                        (src_gain == amg_pkg::GAIN_SW_CTRL) ? amg_pkg::GAIN_DEFAULT : src_gain;
    assign next_pwr   = pin_reset ? '0 : pd_decode(src_pd);
    assign next_cal   = pin_mode_w ? cal_s : cfg.cal;

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            PIN_MODE        <= 1'b0;
            AMP_GAIN_CODE   <= amg_pkg::GAIN_DEFAULT;
            AMP_GAIN_FACTOR <= 8'h01;
            CMP_AB_ON       <= 1'b0;
            CMP_CD_ON       <= 1'b0;
            CONV_ON         <= 1'b0;
            INT_REF_EN      <= 1'b0;
            CAL_START       <= 1'b0;
        end
        else
        begin
            PIN_MODE        <= pin_mode_w;
            AMP_GAIN_CODE   <= next_gain;
            AMP_GAIN_FACTOR <= gain_factor(next_gain);
            CMP_AB_ON       <= next_pwr.cmp_ab;
            CMP_CD_ON       <= next_pwr.cmp_cd;
            CONV_ON         <= next_pwr.conv;
            INT_REF_EN      <= ref_s;
            CAL_START       <= next_cal && !pin_reset;
        end
    end

    // ****************************************
    // wake-up timing
    // ****************************************
    amg_pkg::amg_wake_e              wake;
    amg_pkg::amg_wake_e              next_wake;
    logic                            wake_start;
    logic                            wake_busy;
    logic                            boot;
    logic [amg_pkg::WAKE_CNT_W-1:0]  wake_load;

    // restart on power-up, pin reset, reference change, converters waking
    assign wake_start = boot || pin_reset || (ref_s != INT_REF_EN) || (next_pwr.conv && !CONV_ON);
    assign wake_load  = ref_s ? amg_pkg::WAKE_CNT_W'(INT_WAKE_CYC) : amg_pkg::WAKE_CNT_W'(amg_pkg::EXT_REF_WAKE_CYC);

    amg_wake_timer u_timer (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .start (wake_start),
        .load  (wake_load),
        .busy  (wake_busy)
    );

    always_comb
    begin
        case (wake)
            amg_pkg::WAKE_WAIT:  next_wake = (!wake_busy && !wake_start) ? amg_pkg::WAKE_READY : amg_pkg::WAKE_WAIT;
            amg_pkg::WAKE_READY: next_wake = wake_start ? amg_pkg::WAKE_WAIT : amg_pkg::WAKE_READY;
            default:             next_wake = amg_pkg::WAKE_WAIT;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            wake <= amg_pkg::WAKE_WAIT;
            READY <= 1'b0;
            boot <= 1'b1;
        end
        else
        begin
            wake <= next_wake;
            READY <= (next_wake == amg_pkg::WAKE_READY);
            boot <= 1'b0;
        end
    end

    // ****************************************
    // axi4-lite slave
    // ****************************************
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        aw_take;
    logic        w_take;
    logic        commit;
    logic        wr_ctrl;
    logic        cfg_we;
    logic        ar_take;
    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic        rd_ok;

    assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_take  = S_AXI_WVALID && S_AXI_WREADY;
    assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
    // both halves held and no response pending
    assign commit  = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
    assign wr_ctrl = addr_hit(wr_addr, amg_pkg::CTRL_OFFSET);
    // control register holds gain and power fields
    assign cfg_we  = commit && wr_ctrl && wr_strb[0];

    assign status_word = {21'h000000, CAL_START, READY, INT_REF_EN, PIN_MODE,
                          CONV_ON, CMP_CD_ON, CMP_AB_ON, AMP_GAIN_CODE};
    assign rd_ok   = addr_hit(S_AXI_ARADDR, amg_pkg::CTRL_OFFSET) ||
                     addr_hit(S_AXI_ARADDR, amg_pkg::STATUS_OFFSET);
    assign rd_word = addr_hit(S_AXI_ARADDR, amg_pkg::CTRL_OFFSET) ? {24'h000000, cfg} :
                     addr_hit(S_AXI_ARADDR, amg_pkg::STATUS_OFFSET) ? status_word : 32'h00000000;

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= amg_pkg::RESP_OKAY;
            wr_addr       <= 32'h00000000;
            wr_data       <= 32'h00000000;
            wr_strb       <= 4'h0;
        end
        else
        begin
            if (aw_take)
            begin
                S_AXI_AWREADY <= 1'b0;
                wr_addr       <= S_AXI_AWADDR;
            end
            if (w_take)
            begin
                S_AXI_WREADY <= 1'b0;
                wr_data      <= S_AXI_WDATA;
                wr_strb      <= S_AXI_WSTRB;
            end
            if (commit)
            begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_ctrl ? amg_pkg::RESP_OKAY : amg_pkg::RESP_SLVERR;
            end
            else if (S_AXI_BVALID && S_AXI_BREADY)
            begin
                S_AXI_BVALID  <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY  <= 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h00000000;
            S_AXI_RRESP   <= amg_pkg::RESP_OKAY;
        end
        else if (ar_take)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= rd_word;
            S_AXI_RRESP   <= rd_ok ? amg_pkg::RESP_OKAY : amg_pkg::RESP_SLVERR;
        end
        else if (S_AXI_RVALID && S_AXI_RREADY)
        begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
        end
    end

    // ****************************************
    // configuration register
    // ****************************************
    // cleared by reset and pin reset; pin reset beats a write
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            cfg <= amg_pkg::CTRL_RESET;
        else if (pin_reset)
            cfg <= amg_pkg::CTRL_RESET;
        else if (cfg_we)
            cfg <= wr_data[7:0];
    end

    // ****************************************
    // checks
    // ****************************************
    logic [15:0] low_cnt;

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            low_cnt <= 16'h0000;
        else
            low_cnt <= READY ? 16'h0000 : low_cnt + 16'h0001;
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    a_pin_mode_on:
        assert property ((|{GAIN_SEL_BIT3, GAIN_SEL_BIT2, GAIN_SEL_BIT1, GAIN_SEL_BIT0}) [*4] |-> PIN_MODE)
        else $error("pin mode not entered");
    a_ctrl_mode_on:
        assert property (({GAIN_SEL_BIT3, GAIN_SEL_BIT2, GAIN_SEL_BIT1, GAIN_SEL_BIT0} == 4'h0) [*4] |-> !PIN_MODE)
        else $error("control register mode not entered");
    a_gain_top:
        assert property ((AMP_GAIN_CODE == 4'he) [*2] |-> AMP_GAIN_FACTOR == 8'h80)
        else $error("gain code 14 not 128");
    a_ctrl_gain:
        assert property (!pin_mode_w && cfg.gain inside {[4'h1:4'he]} ##1 $stable(cfg) && !pin_mode_w
                         |-> AMP_GAIN_CODE == $past(cfg.gain))
        else $error("register gain not applied");
    a_pd_all_off:
        assert property (pin_mode_w && pd_s == amg_pkg::PD_ALL_OFF |=> !CMP_AB_ON && !CMP_CD_ON && !CONV_ON)
        else $error("all-low power pins left parts on");
    a_pd_all_on:
        assert property (src_pd == amg_pkg::PD_ALL_ON |=> CMP_AB_ON && CMP_CD_ON && CONV_ON)
        else $error("code 101 did not power all");
    a_pin_reset:
        assert property (pin_reset |=> cfg == amg_pkg::CTRL_RESET && !CONV_ON)
        else $error("pin reset did not clear");
    a_ctrl_no_reset:
        assert property (!pin_mode_w && !cfg_we |=> $stable(cfg))
        else $error("register changed without write");
    a_gain_reserved:
        assert property (src_gain == amg_pkg::GAIN_RESERVED |=> $stable(AMP_GAIN_CODE))
        else $error("reserved gain changed output");
    a_ready_wait:
        assert property ($rose(READY) |-> $past(low_cnt) >=
                         (INT_REF_EN ? 16'(INT_WAKE_CYC) : 16'(amg_pkg::EXT_REF_WAKE_CYC)))
        else $error("ready too early");

endmodule

// *** testbench/amg_pin_host.sv ***
`timescale 1ns/10ps
// ****************************************
// board straps and host pin driver
// ****************************************
module amg_pin_host (
    input  wire logic       clk,
    output logic      [3:0] gain_pins,
    output logic      [2:0] pwr_pins,
    output logic            ref_sel,
    output logic            cal
);
    // strapped low at power-up: control register mode
    initial
    begin
        gain_pins = 4'h0;
        pwr_pins  = 3'h0;
        ref_sel   = 1'h0;
        cal       = 1'h0;
    end

    task automatic drive(input logic [3:0] g, input logic [2:0] p, input logic r, input logic c);
        @(posedge clk);
        gain_pins <= g;
        pwr_pins  <= p;
        ref_sel   <= r;
        cal       <= c;
    endtask

    task automatic all_on(input logic [3:0] g);
        drive(g, 3'h5, ref_sel, cal);
    endtask
endmodule

// *** testbench/adc_mode_gain_powerdown_ctrl_tb_top.sv ***
`timescale 1ns/10ps
module adc_mode_gain_powerdown_ctrl_tb_top;
    localparam int          INT_CYC = 50;
    localparam logic [31:0] CTRL_A  = {28'h0, amg_pkg::CTRL_OFFSET};
    localparam logic [31:0] STAT_A  = {28'h0, amg_pkg::STATUS_OFFSET};
    logic        clk;
    logic        rstn    = 1'h0;
    logic [31:0] awaddr  = 32'h0;
    logic        awvalid = 1'h0;
    logic [31:0] wdata   = 32'h0;
    logic [3:0]  wstrb   = 4'hf;
    logic        wvalid  = 1'h0;
    logic        bready  = 1'h0;
    logic [31:0] araddr  = 32'h0;
    logic        arvalid = 1'h0;
    logic        rready  = 1'h0;
    logic [3:0]  gpin;
    logic [2:0]  ppin;
    logic        reference_select, calpin, pmode, cab, ccd, conv, iref, cals, rdy;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [3:0]  gcode;
    logic [7:0]  gfac;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, d;
    int          err_count  = 0;
    int          n_compared = 0;
    logic [7:0]  gtab [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0c,
                               8'h10, 8'h18, 8'h20, 8'h30, 8'h40, 8'h60, 8'h80, 8'h00};
    wire logic [2:0] pwr = {cab, ccd, conv};

    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    amg_pin_host host_u (.clk(clk), .gain_pins(gpin), .pwr_pins(ppin), .ref_sel(reference_select), .cal(calpin));

    amg_ctrl #(.INT_WAKE_CYC(INT_CYC)) dut_u (
        .REF_CLK(clk), .RSTN(rstn), .GAIN_SEL_BIT3(gpin[3]), .GAIN_SEL_BIT2(gpin[2]),
        .GAIN_SEL_BIT1(gpin[1]), .GAIN_SEL_BIT0(gpin[0]), .PWR_SEL_BIT2(ppin[2]),
        .PWR_SEL_BIT1(ppin[1]), .PWR_SEL_BIT0(ppin[0]), .REFERENCE_SELECT(reference_select),
        .CAL_PIN(calpin), .PIN_MODE(pmode), .AMP_GAIN_CODE(gcode), .AMP_GAIN_FACTOR(gfac),
        .CMP_AB_ON(cab), .CMP_CD_ON(ccd), .CONV_ON(conv), .INT_REF_EN(iref), .CAL_START(cals),
        .READY(rdy), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    // ****************************************
    // common tasks
    // ****************************************
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic timeout;
        err_count++;
        $display("unexpected at %0t: wait bound used up", $time);
        end_of_test();
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // pin changes need the two sync stages plus the output register
    task automatic pins(input logic [3:0] g, input logic [2:0] p, input logic rs, input logic c);
        host_u.drive(g, p, rs, c);
        cyc(5);
    endtask

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] dv, output logic [1:0] rs);
        int i;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= dv;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (awready === 1'h1)
                awvalid <= 1'h0;
            if (wready === 1'h1)
                wvalid <= 1'h0;
            if (bvalid === 1'h1)
                break;
        end
        bready <= 1'h0;
        rs = bresp;
        if (i == 50)
            timeout();
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] dv, output logic [1:0] rs);
        int i;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (arready === 1'h1)
                arvalid <= 1'h0;
            if (rvalid === 1'h1)
                break;
        end
        rready <= 1'h0;
        dv = rdata;
        rs = rresp;
        if (i == 50)
            timeout();
    endtask

    task automatic wait_rdy(input int lim, inout int n);
        for (; n < lim && rdy !== 1'h1; n++)
            @(posedge clk);
        if (n >= lim)
            timeout();
    endtask

    function automatic logic [2:0] pexp(input logic [2:0] c);
        case (c)
            3'h1: return 3'h1;
            3'h2: return 3'h2;
            3'h3: return 3'h4;
            3'h4: return 3'h6;
            3'h5: return 3'h7;
            default: return 3'h0;
        endcase
    endfunction

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        check(pmode, 1'h0, "mode after reset");
        check(gcode, 4'h1, "gain after reset");
        check(gfac, 8'h01, "factor after reset");
        check(pwr, 3'h0, "power after reset");
        axi_rd(CTRL_A, d, r);
        check(d, 32'h0, "ctrl after reset");
        $display("test reset done");
    endtask

    task automatic t_ready;
        int n;
        n = 0;
        wait_rdy(2000, n);
        check(n >= amg_pkg::EXT_REF_WAKE_CYC - 4, 1'h1, "external wake too short");
        pins(4'h0, 3'h0, 1'h1, 1'h0);
        check(rdy, 1'h0, "ready kept");
        check(iref, 1'h1, "internal reference");
        n = 5;
        wait_rdy(200, n);
        check(n >= INT_CYC && n <= INT_CYC + 12, 1'h1, "internal wake");
        pins(4'h0, 3'h0, 1'h0, 1'h0);
        n = 5;
        wait_rdy(2000, n);
        check(n >= amg_pkg::EXT_REF_WAKE_CYC && n <= amg_pkg::EXT_REF_WAKE_CYC + 12, 1'h1, "ext wake");
        $display("test ready done");
    endtask

    task automatic t_ctrl;
        axi_wr(CTRL_A, 32'h53, r);
        check(r, amg_pkg::RESP_OKAY, "ctrl write resp");
        cyc(4);
        check(gcode, 4'h3, "register gain");
        check(pwr, 3'h7, "register power");
        axi_rd(CTRL_A, d, r);
        check(d, 32'h53, "ctrl readback");
        axi_rd(STAT_A, d, r);
        check(d, 32'h73, "status word");
        axi_wr(CTRL_A, 32'hf4, r);
        cyc(4);
        check(pwr, 3'h0, "code 7 off");
        check(gcode, 4'h4, "gain kept on 7");
        check(cals, 1'h1, "register cal");
        axi_rd(CTRL_A, d, r);
        check(d, 32'hf4, "no clear in register mode");
        axi_wr(STAT_A, 32'h0, r);
        check(r, amg_pkg::RESP_SLVERR, "status write");
        axi_rd(32'h8, d, r);
        check(d, 32'h0, "unmapped read data");
        check(r, amg_pkg::RESP_SLVERR, "unmapped read resp");
        $display("test register mode done");
    endtask

    task automatic t_pin_gain;
        for (int g = 1; g < 15; g++)
        begin
            pins(g[3:0], 3'h5, 1'h0, 1'h0);
            check(pmode, 1'h1, "pin mode");
            check(gcode, g[3:0], "pin gain");
            check(gfac, gtab[g], "gain factor");
        end
        pins(4'hf, 3'h5, 1'h0, 1'h0);
        check(gcode, 4'he, "reserved gain");
        $display("test pin gain done");
    endtask

    task automatic t_pin_pwr;
        for (int p = 0; p < 7; p++)
        begin
            pins(4'h2, p[2:0], 1'h0, 1'h1);
            check(pwr, pexp(p[2:0]), "pin power code");
            check(cals, 1'h1, "cal pin");
        end
        host_u.all_on(4'h2);
        cyc(5);
        check(pwr, 3'h7, "all on");
        $display("test pin power done");
    endtask

    task automatic t_pin_reset;
        int n;
        n = 0;
        pins(4'h0, 3'h0, 1'h0, 1'h0);
        axi_wr(CTRL_A, 32'h53, r);
        cyc(3);
        // ready first, so the pin reset has to pull it down
        wait_rdy(2000, n);
        pins(4'h2, 3'h7, 1'h0, 1'h0);
        check(pwr, 3'h0, "pin reset power");
        check(rdy, 1'h0, "wake restarted");
        pins(4'h0, 3'h0, 1'h0, 1'h0);
        check(pmode, 1'h0, "register mode");
        check(gcode, 4'h1, "default gain");
        axi_rd(CTRL_A, d, r);
        check(d, 32'h0, "ctrl cleared");
        $display("test pin reset done");
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        t_reset();
        t_ready();
        t_ctrl();
        t_pin_gain();
        t_pin_pwr();
        t_pin_reset();
        end_of_test();
    end
endmodule
